// ==== rtl/sws_device.sv ====
/*
  Device end of the single-wire link: reset and presence, write and read
  slots, skip net command, read and write memory commands, sleep detect.
  Assumes the line and speed strap are asynchronous, memory read data is
  valid one cycle after the read address changes, and a write consumer
  drains the two-entry buffer through valid and ready.
*/
`default_nettype none
module sws_device #(
  parameter int unsigned RST_DET_STD = sws_pkg::RST_DET_STD_CYC,
  parameter int unsigned PDL_STD = sws_pkg::PDL_MIN_STD_CYC,
  parameter int unsigned WSAMP_STD = sws_pkg::WSAMP_STD_CYC,
  parameter int unsigned SLEEP_CYC = sws_pkg::SLEEP_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Static speed strap
  input wire logic SPEED_SELECT_PIN,
  // Line
  sws_if.dev BUS,
  // Memory read port
  output logic [7:0] RD_ADDR,
  input wire logic [7:0] RD_DATA,
  // Write stream
  output logic WR_VALID,
  output logic [7:0] WR_ADDR,
  output logic [7:0] WR_DATA,
  input wire logic WR_READY,
  // Status
  output logic SLEEP
);
  typedef enum logic [2:0] {L_IDLE, L_RST, L_PWAIT, L_PRES, L_READY, L_SLOT} sws_link_t;
  typedef enum logic [2:0] {P_NET, P_FUNC, P_ADDR, P_WR, P_RD} sws_proto_t;

  sws_link_t link;
  sws_proto_t proto;
  logic line_s1, line_s2, line_q;
  logic speed_s1, speed_s2, speed;
  logic fall, rise, rst_hit, bit_done, byte_done, drop, push, pop;
  logic [31:0] low_cnt, cnt;
  logic [31:0] t_rst_det, t_pdh, t_pdl, t_samp, t_rdv;
  logic [2:0] bit_cnt;
  logic [7:0] shreg, rx_byte;
  logic is_read, tx_load, dq_oe;
  logic pend, tail_v;
  logic [7:0] pend_addr, pend_data, tail_addr, tail_data;

  // Open drain: only ever pull low
  assign BUS.dev_o = 1'h0;
  assign BUS.dev_oe = dq_oe;

  // Two-stage synchronisers, plus a delayed copy for edges
  always_ff @(posedge CLK) begin
    if (RST) begin
      line_s1 <= 1'h1;
      line_s2 <= 1'h1;
      line_q <= 1'h1;
      speed_s1 <= 1'h0;
      speed_s2 <= 1'h0;
    end else begin
      line_s1 <= BUS.line;
      line_s2 <= line_s1;
      line_q <= line_s2;
      speed_s1 <= SPEED_SELECT_PIN;
      speed_s2 <= speed_s1;
    end
  end

  assign fall = line_q & ~line_s2;
  assign rise = ~line_q & line_s2;

  // Timing per speed; reset detect uses the live strap, as none is latched before a reset
  always_comb begin
    t_rst_det = speed_s2 ? sws_pkg::RST_DET_OVD_CYC : RST_DET_STD;
    t_pdh = speed ? sws_pkg::PDH_MIN_OVD_CYC : sws_pkg::PDH_MIN_STD_CYC;
    t_pdl = speed ? sws_pkg::PDL_MIN_OVD_CYC : PDL_STD;
    t_samp = speed ? sws_pkg::WSAMP_OVD_CYC : WSAMP_STD;
    t_rdv = speed ? sws_pkg::RDV_OVD_CYC : sws_pkg::RDV_STD_CYC;
  end

  // Low-time counter; saturates so a stuck line cannot wrap
  always_ff @(posedge CLK) begin
    if (RST || line_s2) begin
      low_cnt <= 32'h0;
    end else if (low_cnt != 32'hffffffff) begin
      low_cnt <= low_cnt + 32'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || line_s2) begin
      SLEEP <= 1'h0;
    end else if (low_cnt >= SLEEP_CYC) begin
      SLEEP <= 1'h1;
    end
  end

  assign rst_hit = ~line_s2 & (low_cnt == t_rst_det);
  assign bit_done = (link == L_SLOT) && (cnt == t_samp);
  assign byte_done = bit_done && (bit_cnt == 3'h7);
  assign rx_byte = {line_s2, shreg[7:1]};
  // Unknown net or function opcode: wait for the next reset
  assign drop = byte_done && (((proto == P_NET) && (rx_byte != sws_pkg::NET_SKIP)) ||
    ((proto == P_FUNC) && (rx_byte != sws_pkg::CMD_READ) &&
    (rx_byte != sws_pkg::CMD_WRITE)));

  // Link layer: reset, presence and slot timing
  always_ff @(posedge CLK) begin
    if (RST) begin
      link <= L_IDLE;
      cnt <= 32'h0;
      dq_oe <= 1'h0;
      speed <= 1'h0;
    end else if (rst_hit) begin
      // speed taken at each reset pulse
      link <= L_RST;
      dq_oe <= 1'h0;
      speed <= speed_s2;
    end else if (drop) begin
      link <= L_IDLE;
    end else begin
      unique case (link)
        L_IDLE: link <= L_IDLE;
        L_RST: if (rise) begin
          link <= L_PWAIT;
          cnt <= 32'h0;
        end
        L_PWAIT: begin
          cnt <= cnt + 32'h1;
          if (cnt + 32'h1 >= t_pdh) begin
            link <= L_PRES;
            cnt <= 32'h0;
            dq_oe <= 1'h1;
          end
        end
        L_PRES: begin
          cnt <= cnt + 32'h1;
          if (cnt + 32'h1 >= t_pdl) begin
            link <= L_READY;
            dq_oe <= 1'h0;
          end
        end
        L_READY: if (fall) begin
          link <= L_SLOT;
          cnt <= 32'h0;
          // a zero bit pulls low at once
          dq_oe <= (proto == P_RD) & ~shreg[0];
        end
        L_SLOT: begin
          cnt <= cnt + 32'h1;
          if (cnt + 32'h1 >= t_rdv) dq_oe <= 1'h0;
          if ((cnt >= t_samp) && line_s2) link <= L_READY;
        end
      endcase
    end
  end

  // Byte layer: commands, address and shifting
  always_ff @(posedge CLK) begin
    if (RST || rst_hit) begin
      proto <= P_NET;
      bit_cnt <= 3'h0;
      tx_load <= 1'h0;
    end else begin
      tx_load <= 1'h0;
      if (bit_done) begin
        bit_cnt <= bit_cnt + 3'h1;
        shreg <= rx_byte;
      end
      if (byte_done) begin
        unique case (proto)
          P_NET: proto <= P_FUNC;
          P_FUNC: begin
            is_read <= rx_byte == sws_pkg::CMD_READ;
            proto <= P_ADDR;
          end
          P_ADDR: begin
            proto <= is_read ? P_RD : P_WR;
            tx_load <= is_read;
          end
          P_WR: proto <= P_WR;
          P_RD: tx_load <= 1'h1;
        endcase
      end
      if (tx_load) shreg <= RD_DATA;
    end
  end

  // address steps per byte, wraps naturally
  always_ff @(posedge CLK) begin
    if (RST) begin
      RD_ADDR <= 8'h0;
    end else if (byte_done && (proto == P_ADDR)) begin
      RD_ADDR <= rx_byte;
    end else if (byte_done && ((proto == P_WR) || (proto == P_RD))) begin
      RD_ADDR <= RD_ADDR + 8'h1;
    end
  end

  // only whole bytes reach the buffer
  always_ff @(posedge CLK) begin
    if (RST) begin
      pend <= 1'h0;
    end else if (byte_done && (proto == P_WR)) begin
      pend <= 1'h1;
      pend_addr <= RD_ADDR;
      pend_data <= rx_byte;
    end else if (push) begin
      pend <= 1'h0;
    end
  end

  // Two-entry buffer; a full tail holds the pending byte back
  assign push = pend & ~tail_v;
  assign pop = WR_VALID & WR_READY;
  always_ff @(posedge CLK) begin
    if (RST) begin
      WR_VALID <= 1'h0;
      WR_ADDR <= 8'h0;
      WR_DATA <= 8'h0;
      tail_v <= 1'h0;
    end else if (!WR_VALID || pop) begin
      if (tail_v) begin
        WR_VALID <= 1'h1;
        WR_ADDR <= tail_addr;
        WR_DATA <= tail_data;
        tail_v <= 1'h0;
      end else begin
        WR_VALID <= push;
        WR_ADDR <= pend_addr;
        WR_DATA <= pend_data;
      end
    end else if (push) begin
      tail_v <= 1'h1;
      tail_addr <= pend_addr;
      tail_data <= pend_data;
    end
  end
endmodule
`default_nettype wire

// ==== include/sws_pkg.sv ====
/*
  Shared constants and types for the single-wire slave link: opcodes, bus
  timing in microseconds and the cycle counts derived from the clock rate.
  Assumes a single 200 MHz clock on both ends and an open-drain line.
*/
// Contract
// - Read 69h and write 6Ch, address, bytes
// - Master starts all signalling except presence
// - Master reset low 480-960us, 48-80us
// - Master releases line at least 480/48us
// - Presence after 15-60us wait, 60-240us low
// - First byte after presence is net-level
// - Write slots 60-120us/6-16us, 1us recovery
// - Device samples write bit 15-60us/2-6us
// - Write one releases within 15us/2us
// - Write zero holds low whole slot
// - Read slot starts with 1us low
// - Read bit held until master sample
// - Device releases line before slot end
// - Read slots same length, 1us recovery
// - Sleep 2.0-2.4s after line low
// - Speed pin: 0 standard, 1 overdrive
// - Low over 120us/16us means reset
// - Address advances per byte, wraps to 00h
// - Partial write bytes are discarded
`default_nettype none
package sws_pkg;
  // Function and net-level opcodes
  localparam logic [7:0] CMD_READ = 8'h69;
  localparam logic [7:0] CMD_WRITE = 8'h6c;
  localparam logic [7:0] NET_SKIP = 8'hcc;
  // Clock cycles per microsecond
  localparam int unsigned CLK_MHZ = 200;
  // Bus times in microseconds, sleep in milliseconds; standard then overdrive
  localparam int unsigned RSTL_STD_US = 480;
  localparam int unsigned RSTL_OVD_US = 48;
  localparam int unsigned RSTH_STD_US = 480;
  localparam int unsigned RSTH_OVD_US = 48;
  localparam int unsigned PDH_MIN_STD_US = 15;
  localparam int unsigned PDH_MIN_OVD_US = 2;
  localparam int unsigned PDH_MAX_STD_US = 60;
  localparam int unsigned PDH_MAX_OVD_US = 6;
  localparam int unsigned PDL_MIN_STD_US = 60;
  localparam int unsigned PDL_MIN_OVD_US = 8;
  localparam int unsigned SLOT_MIN_STD_US = 60;
  localparam int unsigned SLOT_MIN_OVD_US = 6;
  localparam int unsigned REC_US = 1;
  localparam int unsigned ONE_LOW_US = 1;
  localparam int unsigned RDV_STD_US = 15;
  localparam int unsigned RDV_OVD_US = 2;
  localparam int unsigned WSAMP_MIN_STD_US = 15;
  localparam int unsigned WSAMP_MAX_STD_US = 60;
  localparam int unsigned WSAMP_MIN_OVD_US = 2;
  localparam int unsigned WSAMP_MAX_OVD_US = 6;
  localparam int unsigned RST_DET_STD_US = 120;
  localparam int unsigned RST_DET_OVD_US = 16;
  localparam int unsigned SLEEP_MS = 2000;
  // Derived cycle counts; integer microseconds give exact counts
  localparam int unsigned RSTL_STD_CYC = RSTL_STD_US * CLK_MHZ;
  localparam int unsigned RSTL_OVD_CYC = RSTL_OVD_US * CLK_MHZ;
  localparam int unsigned RSTH_STD_CYC = RSTH_STD_US * CLK_MHZ;
  localparam int unsigned RSTH_OVD_CYC = RSTH_OVD_US * CLK_MHZ;
  localparam int unsigned PDH_MIN_STD_CYC = PDH_MIN_STD_US * CLK_MHZ;
  localparam int unsigned PDH_MIN_OVD_CYC = PDH_MIN_OVD_US * CLK_MHZ;
  localparam int unsigned PDH_MAX_STD_CYC = PDH_MAX_STD_US * CLK_MHZ;
  localparam int unsigned PDH_MAX_OVD_CYC = PDH_MAX_OVD_US * CLK_MHZ;
  localparam int unsigned PDL_MIN_STD_CYC = PDL_MIN_STD_US * CLK_MHZ;
  localparam int unsigned PDL_MIN_OVD_CYC = PDL_MIN_OVD_US * CLK_MHZ;
  localparam int unsigned SLOT_MIN_STD_CYC = SLOT_MIN_STD_US * CLK_MHZ;
  localparam int unsigned SLOT_MIN_OVD_CYC = SLOT_MIN_OVD_US * CLK_MHZ;
  localparam int unsigned REC_CYC = REC_US * CLK_MHZ;
  localparam int unsigned ONE_LOW_CYC = ONE_LOW_US * CLK_MHZ;
  localparam int unsigned RDV_STD_CYC = RDV_STD_US * CLK_MHZ;
  localparam int unsigned RDV_OVD_CYC = RDV_OVD_US * CLK_MHZ;
  // Write sample point sits mid-window for margin on both sides
  localparam int unsigned WSAMP_STD_CYC = (WSAMP_MIN_STD_US + WSAMP_MAX_STD_US) * CLK_MHZ / 2;
  localparam int unsigned WSAMP_OVD_CYC = (WSAMP_MIN_OVD_US + WSAMP_MAX_OVD_US) * CLK_MHZ / 2;
  localparam int unsigned RST_DET_STD_CYC = RST_DET_STD_US * CLK_MHZ;
  localparam int unsigned RST_DET_OVD_CYC = RST_DET_OVD_US * CLK_MHZ;
  localparam int unsigned SLEEP_CYC = SLEEP_MS * CLK_MHZ * 1000;
  // Master byte-level operations
  typedef enum logic [1:0] {SWS_OP_RESET, SWS_OP_WRITE, SWS_OP_READ} sws_op_t;
endpackage
`default_nettype wire

// ==== include/sws_if.sv ====
/*
  Single open-drain line shared by the device end and the master end.
  Assumes an external pullup: the line is high unless an end pulls it low.
*/
`default_nettype none
interface sws_if;
  logic line;
  logic dev_o;
  logic dev_oe;
  logic mst_o;
  logic mst_oe;
  // Wired-AND with pullup
  assign line = ~((dev_oe & ~dev_o) | (mst_oe & ~mst_o));
  modport dev(input line, output dev_o, output dev_oe);
  modport mst(input line, output mst_o, output mst_oe);
endinterface
`default_nettype wire

// ==== rtl/sws_master.sv ====
/*
  Master end of the single-wire link: issues reset with presence check,
  byte writes and byte reads, least significant bit first.
  Assumes the same open-drain line and a caller on the same clock.
*/
`default_nettype none
module sws_master #(
  parameter int unsigned RSTL_STD = sws_pkg::RSTL_STD_CYC,
  parameter int unsigned RSTH_STD = sws_pkg::RSTH_STD_CYC,
  parameter int unsigned PDH_MAX_STD = sws_pkg::PDH_MAX_STD_CYC,
  parameter int unsigned SLOT_STD = sws_pkg::SLOT_MIN_STD_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Static speed strap
  input wire logic SPEED_SELECT_PIN,
  // Line
  sws_if.mst BUS,
  // Command
  input wire logic CMD_VALID,
  input wire sws_pkg::sws_op_t CMD_OP,
  input wire logic [7:0] CMD_DATA,
  output logic CMD_READY,
  // Response
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_PRESENT
);
  typedef enum logic {M_IDLE, M_BIT} sws_mst_t;

  sws_mst_t state;
  sws_pkg::sws_op_t op, next_op;
  logic line_s1, line_s2, sp_s1, sp_s2;
  logic mst_oe, samp, next_bit;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [31:0] cnt, lo_len, smp_at, tot_len;
  logic [31:0] next_lo, next_smp, next_tot;
  logic [31:0] t_rstl, t_rsth, t_pdh, t_slot, t_rdv;

  assign BUS.mst_o = 1'h0;
  assign BUS.mst_oe = mst_oe;

  // Synchroniser for the line
  always_ff @(posedge CLK) begin
    if (RST) begin
      line_s1 <= 1'h1;
      line_s2 <= 1'h1;
    end else begin
      line_s1 <= BUS.line;
      line_s2 <= line_s1;
    end
  end

  // Strap synchroniser runs through reset, so a command taken at release sees the strap
  always_ff @(posedge CLK) begin
    sp_s1 <= SPEED_SELECT_PIN;
    sp_s2 <= sp_s1;
  end

  always_comb begin
    t_rstl = sp_s2 ? sws_pkg::RSTL_OVD_CYC : RSTL_STD;
    t_rsth = sp_s2 ? sws_pkg::RSTH_OVD_CYC : RSTH_STD;
    t_pdh = sp_s2 ? sws_pkg::PDH_MAX_OVD_CYC : PDH_MAX_STD;
    t_slot = sp_s2 ? sws_pkg::SLOT_MIN_OVD_CYC : SLOT_STD;
    t_rdv = sp_s2 ? sws_pkg::RDV_OVD_CYC : sws_pkg::RDV_STD_CYC;
  end

  // Shape of the next slot
  assign next_op = (state == M_IDLE) ? CMD_OP : op;
  assign next_bit = (state == M_IDLE) ? CMD_DATA[0] : shreg[1];
  always_comb begin
    next_lo = sws_pkg::ONE_LOW_CYC;
    next_smp = t_rdv;
    next_tot = t_slot + sws_pkg::REC_CYC;
    unique case (next_op)
      // reset low; release, then presence sampled
      sws_pkg::SWS_OP_RESET: begin
        next_lo = t_rstl;
        next_smp = t_rstl + t_pdh;
        next_tot = t_rstl + t_rsth;
      end
      // short low for one; whole slot for zero
      sws_pkg::SWS_OP_WRITE: if (!next_bit) next_lo = t_slot;
      sws_pkg::SWS_OP_READ: next_lo = sws_pkg::ONE_LOW_CYC;
    endcase
  end

  // every slot begins here; falling edge starts it
  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= M_IDLE;
      op <= sws_pkg::SWS_OP_RESET;
      CMD_READY <= 1'h1;
      RSP_VALID <= 1'h0;
      RSP_DATA <= 8'h0;
      RSP_PRESENT <= 1'h0;
      mst_oe <= 1'h0;
      cnt <= 32'h0;
      bit_cnt <= 3'h0;
      samp <= 1'h0;
    end else begin
      RSP_VALID <= 1'h0;
      unique case (state)
        M_IDLE: if (CMD_VALID) begin
          op <= CMD_OP;
          shreg <= CMD_DATA;
          bit_cnt <= 3'h0;
          CMD_READY <= 1'h0;
          state <= M_BIT;
          cnt <= 32'h0;
          mst_oe <= 1'h1;
          lo_len <= next_lo;
          smp_at <= next_smp;
          tot_len <= next_tot;
        end
        M_BIT: begin
          cnt <= cnt + 32'h1;
          mst_oe <= (cnt + 32'h1) < lo_len;
          // read bit sampled at valid time
          if (cnt == smp_at) samp <= line_s2;
          if (cnt + 32'h1 >= tot_len) begin
            shreg <= {samp, shreg[7:1]};
            bit_cnt <= bit_cnt + 3'h1;
            if ((op == sws_pkg::SWS_OP_RESET) || (bit_cnt == 3'h7)) begin
              state <= M_IDLE;
              CMD_READY <= 1'h1;
              RSP_VALID <= 1'h1;
              RSP_DATA <= {samp, shreg[7:1]};
              if (op == sws_pkg::SWS_OP_RESET) RSP_PRESENT <= ~samp;
            end else begin
              cnt <= 32'h0;
              mst_oe <= 1'h1;
              lo_len <= next_lo;
              smp_at <= next_smp;
              tot_len <= next_tot;
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== test/sws_link_sva.sv ====
/*
  Timing checker for one single-wire link run at overdrive speed.
  Assumes both ends use overdrive and a 5 ns clock; sees only the line signals.
*/
`default_nettype none
module sws_link_sva (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Shared line and drivers
  input wire logic line,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic mst_o,
  input wire logic mst_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Overdrive figures in clock cycles
  localparam int PDH_MIN = 400;
  localparam int PDH_MAX = 1200;
  localparam int PDL_MIN = 1600;
  localparam int PDL_MAX = 4800;
  localparam int RDV = 400;
  localparam int SLOT = 1200;
  localparam int RST_DET = 3200;
  localparam int RSTL_MIN = 9600;
  localparam int RSTL_MAX = 16000;
  localparam int RSTH_MIN = 9600;
  localparam int REC = 200;
  localparam int LOW1_MAX = 400;
  logic [15:0] low_cnt, hi_cnt, dev_cnt, mst_cnt, mst_idle, since_fall;
  logic line_q, dev_q, after_rst, pres, long_rst;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  function automatic logic [15:0] sat(input logic [15:0] x);
    return (x == 16'hffff) ? x : x + 16'h0001;
  endfunction
  // Run lengths; idle counts start saturated so the first slot is legal
  always_ff @(posedge CLK) begin
    if (RST) begin
      low_cnt <= 16'h0000;
      hi_cnt <= 16'hffff;
      dev_cnt <= 16'h0000;
      mst_cnt <= 16'h0000;
      mst_idle <= 16'hffff;
      since_fall <= 16'hffff;
    end else begin
      low_cnt <= line ? 16'h0000 : sat(low_cnt);
      hi_cnt <= line ? sat(hi_cnt) : 16'h0000;
      dev_cnt <= dev_oe ? sat(dev_cnt) : 16'h0000;
      mst_cnt <= mst_oe ? sat(mst_cnt) : 16'h0000;
      mst_idle <= mst_oe ? 16'h0000 : sat(mst_idle);
      since_fall <= (line_q && !line) ? 16'h0001 : sat(since_fall);
    end
  end
  // Tells presence pulses apart from read zeros, reset pulses from slots
  always_ff @(posedge CLK) begin
    if (RST) begin
      line_q <= 1'b1;
      dev_q <= 1'b0;
      after_rst <= 1'b0;
      pres <= 1'b0;
      long_rst <= 1'b0;
    end else begin
      line_q <= line;
      dev_q <= dev_oe;
      if (line && low_cnt > RST_DET) after_rst <= 1'b1;
      else if (!line) after_rst <= 1'b0;
      if (dev_oe && !dev_q) pres <= after_rst;
      if (!mst_oe && mst_cnt != 16'h0000) long_rst <= (mst_cnt > RST_DET);
    end
  end
  pres_wait_a: assert property ($rose(dev_oe) && after_rst |-> hi_cnt >= PDH_MIN && hi_cnt <= PDH_MAX)
    else $error("presence began outside its wait window");
  pres_len_a: assert property ($fell(dev_oe) && pres |-> dev_cnt >= PDL_MIN && dev_cnt <= PDL_MAX)
    else $error("presence pulse length out of range");
  read_hold_a: assert property ($fell(dev_oe) && !pres |-> since_fall >= RDV && since_fall < SLOT)
    else $error("read bit released too early or too late");
  dev_start_a: assert property ($rose(dev_oe) |-> after_rst || !$past(line))
    else $error("device started a pulse on an idle line");
  rst_low_a: assert property ($fell(mst_oe) && mst_cnt > RST_DET |-> mst_cnt >= RSTL_MIN && mst_cnt <= RSTL_MAX)
    else $error("reset pulse length out of range");
  rst_high_a: assert property ($rose(mst_oe) && long_rst |-> mst_idle >= RSTH_MIN)
    else $error("line not released long enough after reset");
  slot_rec_a: assert property ($rose(mst_oe) && !long_rst |-> hi_cnt >= REC)
    else $error("slot started without recovery time");
  short_low_a: assert property ($fell(mst_oe) && mst_cnt <= LOW1_MAX |-> mst_cnt >= REC)
    else $error("short low pulse out of range");
  zero_low_a: assert property ($fell(mst_oe) && mst_cnt > LOW1_MAX && mst_cnt <= RST_DET |-> mst_cnt >= SLOT)
    else $error("write zero low time out of range");
  wired_and_a: assert property (line == !(dev_oe || mst_oe) && !dev_o && !mst_o)
    else $error("line level does not follow the pull-downs");
  cover property ($fell(dev_oe) && pres);
  cover property ($fell(dev_oe) && !pres);
  cover property ($rose(mst_oe) && long_rst);
endmodule
`default_nettype wire

// ==== test/single_wire_slave_signaling_tb.sv ====
/*
  Bench with three master and device pairs at overdrive speed, run in parallel:
  write stream, read stream, sleep and a refused command.
  Assumes the package and the interface are compiled first.
*/
`default_nettype none
module single_wire_slave_signaling_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LINKS = 3;
  localparam int TIMEOUT = 90000;
  localparam int unsigned SLEEP_SHORT = 5000;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic cmd_valid [LINKS];
  sws_pkg::sws_op_t cmd_op [LINKS];
  logic [7:0] cmd_data [LINKS];
  logic wr_ready [LINKS];
  wire logic cmd_ready [LINKS];
  wire logic rsp_valid [LINKS];
  wire logic [7:0] rsp_data [LINKS];
  wire logic rsp_present [LINKS];
  wire logic [7:0] rd_addr [LINKS];
  wire logic [7:0] rd_data [LINKS];
  wire logic wr_valid [LINKS];
  wire logic [7:0] wr_addr [LINKS];
  wire logic [7:0] wr_data [LINKS];
  wire logic sleep [LINKS];
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  // Memory image: a fixed pattern of the address
  function automatic logic [7:0] mem_val(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction
  // Link 2 sleeps early so a reset pulse is long enough to trigger it
  for (genvar g = 0; g < LINKS; g++) begin : g_link
    sws_if u_if ();
    sws_master u_sws_master (
      .CLK(CLK), .RST(RST), .SPEED_SELECT_PIN(1'b1), .BUS(u_if),
      .CMD_VALID(cmd_valid[g]), .CMD_OP(cmd_op[g]), .CMD_DATA(cmd_data[g]),
      .CMD_READY(cmd_ready[g]), .RSP_VALID(rsp_valid[g]), .RSP_DATA(rsp_data[g]),
      .RSP_PRESENT(rsp_present[g])
    );
    sws_device #(.SLEEP_CYC(g == 2 ? SLEEP_SHORT : sws_pkg::SLEEP_CYC)) u_sws_device (
      .CLK(CLK), .RST(RST), .SPEED_SELECT_PIN(1'b1), .BUS(u_if),
      .RD_ADDR(rd_addr[g]), .RD_DATA(rd_data[g]), .WR_VALID(wr_valid[g]),
      .WR_ADDR(wr_addr[g]), .WR_DATA(wr_data[g]), .WR_READY(wr_ready[g]), .SLEEP(sleep[g])
    );
    assign rd_data[g] = mem_val(rd_addr[g]);
  end
  // Checker watches the read link, which sees every kind of slot
  sws_link_sva u_sws_link_sva (
    .CLK(CLK), .RST(RST), .line(g_link[1].u_if.line), .dev_o(g_link[1].u_if.dev_o),
    .dev_oe(g_link[1].u_if.dev_oe), .mst_o(g_link[1].u_if.mst_o),
    .mst_oe(g_link[1].u_if.mst_oe)
  );
  always #2.5 CLK = ~CLK;
  // Hang guard: a link that never answers would stall the run
  always @(posedge CLK) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One byte operation; entered just after an edge with the master idle
  task automatic do_op(input int l, input sws_pkg::sws_op_t op, input logic [7:0] d,
                       output logic [7:0] r);
    int n = 0;
    cmd_op[l] = op;
    cmd_data[l] = d;
    cmd_valid[l] = 1'b1;
    @(posedge CLK);
    #1;
    cmd_valid[l] = 1'b0;
    check_bit(cmd_ready[l], 1'b0);
    while (rsp_valid[l] !== 1'b1 && n < 25000) begin
      @(posedge CLK);
      #1;
      n++;
    end
    // A missing answer counts against the run
    if (n >= 25000) mismatches++;
    check_bit(cmd_ready[l], 1'b1);
    r = rsp_data[l];
  endtask
  task automatic send(input int l, input logic [7:0] q[$]);
    logic [7:0] r;
    foreach (q[i]) do_op(l, sws_pkg::SWS_OP_WRITE, q[i], r);
  endtask
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // Consumer stalls through both bytes, so the buffer must hold them
  task automatic run_write();
    logic [7:0] r;
    do_op(0, sws_pkg::SWS_OP_RESET, 8'h00, r);
    check_bit(rsp_present[0], 1'b1);
    send(0, '{sws_pkg::NET_SKIP, sws_pkg::CMD_WRITE, 8'hff, 8'ha5, 8'h3c});
    wait_cycles(4);
    check_bit(wr_valid[0], 1'b1);
    check_byte(wr_addr[0], 8'hff);
    check_byte(wr_data[0], 8'ha5);
    wr_ready[0] = 1'b1;
    wait_cycles(1);
    check_bit(wr_valid[0], 1'b1);
    check_byte(wr_addr[0], 8'h00);
    check_byte(wr_data[0], 8'h3c);
    wait_cycles(1);
    wr_ready[0] = 1'b0;
    check_bit(wr_valid[0], 1'b0);
    $display("test write_stream done");
  endtask
  // Read across the top of the address space
  task automatic run_read();
    logic [7:0] r;
    do_op(1, sws_pkg::SWS_OP_RESET, 8'h00, r);
    check_bit(rsp_present[1], 1'b1);
    send(1, '{sws_pkg::NET_SKIP, sws_pkg::CMD_READ, 8'hff});
    do_op(1, sws_pkg::SWS_OP_READ, 8'h00, r);
    check_byte(r, mem_val(8'hff));
    do_op(1, sws_pkg::SWS_OP_READ, 8'h00, r);
    check_byte(r, mem_val(8'h00));
    check_byte(rd_addr[1], 8'h01);
    $display("test read_stream done");
  endtask
  // Reset pulse outlasts the short sleep count; then a function byte without skip
  task automatic run_sleep();
    logic [7:0] r;
    fork
      do_op(2, sws_pkg::SWS_OP_RESET, 8'h00, r);
      begin
        wait_cycles(SLEEP_SHORT - 10);
        check_bit(sleep[2], 1'b0);
        wait_cycles(40);
        check_bit(sleep[2], 1'b1);
      end
    join
    check_bit(sleep[2], 1'b0);
    send(2, '{sws_pkg::CMD_WRITE, sws_pkg::CMD_WRITE, 8'h10, 8'h77});
    wait_cycles(4);
    check_bit(wr_valid[2], 1'b0);
    $display("test sleep_and_refuse done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < LINKS; i++) begin
      cmd_valid[i] = 1'b0;
      cmd_op[i] = sws_pkg::SWS_OP_RESET;
      cmd_data[i] = 8'h00;
      wr_ready[i] = 1'b0;
    end
    wait_cycles(5);
    RST = 1'b0;
    fork
      run_write();
      run_read();
      run_sleep();
    join
    finish_test();
  end
endmodule
`default_nettype wire
